// file: rtl/spdc_target.sv
/*
 spdc_target: spi target front end with status segment, header detect and daisy pass.
 assumes: link pins are asynchronous to CLK_SYS and sampled through two flip-flops;
 an external register file answers RD_DATA combinationally from RD_FEATURE/RD_PORT.
*/
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module spdc_target #(
   parameter int NPORT = spdc_pkg::NPORT
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   spdc_if.target LINK,
   input wire logic [spdc_pkg::FAULT_W-1:0] FAULT,
   input wire logic [spdc_pkg::BYTE_BITS-1:0] RD_DATA,
   output logic [spdc_pkg::FEAT_W-1:0] RD_FEATURE,
   output logic [spdc_pkg::PORT_W-1:0] RD_PORT,
   output logic RD_STB,
   output logic WR_STB,
   output logic [spdc_pkg::FEAT_W-1:0] WR_FEATURE,
   output logic [NPORT-1:0] WR_MASK,
   output logic [NPORT*spdc_pkg::BYTE_BITS-1:0] WR_VALUE,
   output logic [spdc_pkg::CHAIN_W-1:0] CHAIN_LEN,
   output logic HDR_SEEN
);
   localparam int SB = spdc_pkg::SEG_BITS;
   localparam int BB = spdc_pkg::BYTE_BITS;

   // synchronisers: stage 1 feeds stage 2 only
   logic sclk_s1_q, sclk_s2_q, sclk_s3_q; // serial clock stages
   logic cs_s1_q, cs_s2_q, cs_s3_q; // chip select stages
   logic sdi_s1_q, sdi_s2_q; // data stages

   // decoded link events
   logic sel; // chip select active
   logic rise; // rising sclk inside a frame
   logic fall; // falling sclk inside a frame
   logic frame_start; // chip select fell
   logic frame_end; // chip select rose

   // receive state
   spdc_pkg::spdc_seg_t seg_q; // current segment kind
   logic [spdc_pkg::SEG_CNT_W-1:0] cnt_q; // bit within segment
   logic [SB-1:0] in_q; // receive shift register
   logic [SB-1:0] word; // segment including incoming bit
   logic seg_done; // 16-bit segment completes
   logic byte_done; // data byte completes
   logic rnw_q; // latched read/write bit
   logic cmd_q; // an address segment arrived
   logic [spdc_pkg::BYTE_CNT_W-1:0] nbytes_q; // complete data bytes
   logic [BB-1:0] data_q; // last complete data byte
   logic multi_q; // multi-port bit
   logic fetch_q; // load read data next cycle

   // transmit state
   logic [SB-1:0] out_q; // transmit / pass-through shift register
   logic sdo_q; // pin register

   // two-flop sampling of link pins
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         sdi_s1_q <= 1'b0;
         sdi_s2_q <= 1'b0;
      end else begin
         sclk_s1_q <= LINK.sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         cs_s1_q <= LINK.cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         sdi_s1_q <= LINK.sdi;
         sdi_s2_q <= sdi_s1_q;
      end
   end

   // edge decode; activity with chip select high is ignored
   assign sel = ~cs_s2_q;
   assign rise = sel & sclk_s2_q & ~sclk_s3_q;
   assign fall = sel & ~sclk_s2_q & sclk_s3_q;
   assign frame_start = cs_s3_q & ~cs_s2_q;
   assign frame_end = ~cs_s3_q & cs_s2_q;

   // incoming segment, msb first
   assign word = {in_q[SB-2:0], sdi_s2_q};
   assign seg_done = rise && (seg_q != spdc_pkg::SPDC_SEG_DATA) &&
                     (cnt_q == spdc_pkg::SEG_CNT_W'(SB - 1));
   assign byte_done = rise && (seg_q == spdc_pkg::SPDC_SEG_DATA) &&
                      (cnt_q == spdc_pkg::SEG_CNT_W'(BB - 1));

   // receive shifter
   always_ff @(posedge CLK_SYS) begin
      if (RST || frame_start) begin
         in_q <= '0;
      end else if (rise) begin
         in_q <= word;
      end
   end

   // segment sequencing: header optional, then address, then bytes
   always_ff @(posedge CLK_SYS) begin
      if (RST || frame_start) begin
         seg_q <= spdc_pkg::SPDC_SEG_FIRST;
         cnt_q <= '0;
      end else if (seg_done) begin
         cnt_q <= '0;
         // header only in first position, else it is the address
         if (seg_q == spdc_pkg::SPDC_SEG_FIRST &&
             word[spdc_pkg::ID_HI:spdc_pkg::ID_LO] == spdc_pkg::HDR_ID) begin
            seg_q <= spdc_pkg::SPDC_SEG_ADDR;
         end else begin
            seg_q <= spdc_pkg::SPDC_SEG_DATA;
         end
      end else if (byte_done) begin
         cnt_q <= '0;
      end else if (rise) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // header capture: device count, bit 13 ignored
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         CHAIN_LEN <= spdc_pkg::CHAIN_RST;
         HDR_SEEN <= 1'b0;
      end else if (frame_start) begin
         HDR_SEEN <= 1'b0;
      end else if (seg_done && seg_q == spdc_pkg::SPDC_SEG_FIRST &&
                   word[spdc_pkg::ID_HI:spdc_pkg::ID_LO] == spdc_pkg::HDR_ID) begin
         CHAIN_LEN <= word[spdc_pkg::CHAIN_HI:0];
         HDR_SEEN <= 1'b1;
      end
   end

   // address segment: operation, feature, port, multi-port
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rnw_q <= 1'b0;
         cmd_q <= 1'b0;
         multi_q <= 1'b0;
         RD_FEATURE <= '0;
         RD_PORT <= '0;
         fetch_q <= 1'b0;
      end else begin
         fetch_q <= 1'b0;
         if (frame_start) begin
            cmd_q <= 1'b0;
         end else if (seg_done && !(seg_q == spdc_pkg::SPDC_SEG_FIRST &&
                      word[spdc_pkg::ID_HI:spdc_pkg::ID_LO] == spdc_pkg::HDR_ID)) begin
            cmd_q <= 1'b1;
            rnw_q <= word[spdc_pkg::RNW_POS];
            RD_FEATURE <= word[spdc_pkg::FEAT_HI:spdc_pkg::FEAT_LO];
            RD_PORT <= word[spdc_pkg::PORT_HI:spdc_pkg::PORT_LO];
            multi_q <= word[spdc_pkg::MULTI_POS];
            fetch_q <= 1'b1;
         end
      end
   end

   // read request pulse, one cycle after the address completes
   assign RD_STB = fetch_q;

   // data bytes: keep the last whole byte and count them
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         data_q <= spdc_pkg::BYTE_RST;
         nbytes_q <= '0;
      end else if (frame_start) begin
         nbytes_q <= '0;
      end else if (byte_done) begin
         data_q <= word[BB-1:0];
         if (nbytes_q != '1) begin
            nbytes_q <= nbytes_q + 1'b1;
         end
      end
   end

   // transmit: status first, then any header passed through, then register byte, then pass-through
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         out_q <= '0;
         sdo_q <= 1'b0;
      end else if (frame_start) begin
         out_q <= {spdc_pkg::STAT_ID, FAULT, spdc_pkg::BYTE_RST};
         sdo_q <= spdc_pkg::STAT_ID[1]; // first status bit before first edge
      end else begin
         if (fetch_q) begin
            out_q[SB-1:BB] <= RD_DATA;
         end else if (rise) begin
            out_q <= {out_q[SB-2:0], sdi_s2_q};
         end
         if (fall) begin
            sdo_q <= out_q[SB-1];
         end
      end
   end
   assign LINK.sdo = sdo_q;

   // write commit at chip select release on whole bytes only
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         WR_STB <= 1'b0;
         WR_FEATURE <= '0;
      end else begin
         WR_STB <= 1'b0;
         if (frame_end && cmd_q && !rnw_q && nbytes_q != '0 && cnt_q == '0) begin
            WR_STB <= 1'b1;
            WR_FEATURE <= RD_FEATURE;
         end
      end
   end

   // per-port mask and value; multi-port spreads data bit n over port n
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      always_ff @(posedge CLK_SYS) begin
         if (RST) begin
            WR_MASK[p] <= 1'b0;
            WR_VALUE[p*BB +: BB] <= spdc_pkg::BYTE_RST;
         end else if (frame_end) begin
            if (multi_q) begin
               WR_MASK[p] <= 1'b1;
               WR_VALUE[p*BB +: BB] <= {BB{data_q[p]}};
            end else begin
               WR_MASK[p] <= (RD_PORT == spdc_pkg::PORT_W'(p));
               WR_VALUE[p*BB +: BB] <= data_q;
            end
         end
      end
   end

endmodule : spdc_target

// file: rtl/spdc_pkg.sv
/*
 spdc_pkg: shared constants for the spi target daisy-chain front end and its controller.
 assumes: both ends and the bench import nothing and refer to names as spdc_pkg::name.
*/
package spdc_pkg;
   localparam int SEG_BITS = 16; // status, header and address segments
   localparam int BYTE_BITS = 8; // one data byte
   localparam int WORD_BITS = 24; // basic word: address plus one byte
   localparam int NPORT = 3; // io ports 0..2
   localparam int CHAIN_W = 13; // header device count width
   localparam int FEAT_W = 5; // feature address width
   localparam int PORT_W = 3; // port select width
   localparam int FAULT_W = 6; // fault bits copied into status
   localparam int SEG_CNT_W = 4; // bit counter within a segment
   localparam int BYTE_CNT_W = 8; // saturating count of data bytes
   // segment identifiers in bits [15:14]
   localparam logic [1:0] HDR_ID = 2'h1; // header marker 0,1
   localparam logic [1:0] STAT_ID = 2'h3; // status marker 1,1
   // field positions inside a 16-bit segment
   localparam int ID_HI = 15;
   localparam int ID_LO = 14;
   localparam int RNW_POS = 15; // 1 read, 0 write
   localparam int FEAT_HI = 12; // word bit 20
   localparam int FEAT_LO = 8; // word bit 16
   localparam int PORT_HI = 6; // word bit 14
   localparam int PORT_LO = 4; // word bit 12
   localparam int MULTI_POS = 0; // word bit 8
   localparam int CHAIN_HI = 12;
   // reset values
   localparam logic [BYTE_BITS-1:0] BYTE_RST = 8'h00;
   localparam logic [CHAIN_W-1:0] CHAIN_RST = 13'h0000;
   // controller clock divider default: half period in system cycles (160 ns link)
   localparam int SCLK_HALF = 4;
   localparam int CNT_W = 8; // controller phase counter width
   localparam int FRAME_MAX = 40; // header + address + one byte
   localparam int BIT_CNT_W = 6; // controller bit counter width
   // segment tracking in the target
   typedef enum logic [1:0] {SPDC_SEG_FIRST, SPDC_SEG_ADDR, SPDC_SEG_DATA} spdc_seg_t;
   // controller sequence
   typedef enum logic [2:0] {SPDC_C_IDLE, SPDC_C_LEAD, SPDC_C_LOW, SPDC_C_HIGH, SPDC_C_TAIL}
      spdc_cst_t;
endpackage : spdc_pkg

// file: rtl/spdc_if.sv
/*
 spdc_if: the four-wire link between controller and target.
 assumes: controller drives sclk, cs_n and sdi; target drives sdo; no tristate.
*/
`timescale 1ns/1ps
interface spdc_if;
   logic sclk; // serial clock, idles low
   logic cs_n; // chip select, active low
   logic sdi; // controller to target data
   logic sdo; // target to controller data
   modport target (input sclk, input cs_n, input sdi, output sdo);
   modport ctrl (output sclk, output cs_n, output sdi, input sdo);
endinterface : spdc_if

// file: rtl/spdc_ctrl.sv
/*
 spdc_ctrl: spi mode-0 controller end; one frame of optional header, address and one byte.
 assumes: sdo comes from another domain and is sampled through two flip-flops.
*/
`timescale 1ns/1ps
module spdc_ctrl #(
   parameter int HALF = spdc_pkg::SCLK_HALF
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   spdc_if.ctrl LINK,
   input wire logic START,
   input wire logic RNW,
   input wire logic [spdc_pkg::FEAT_W-1:0] FEATURE,
   input wire logic [spdc_pkg::PORT_W-1:0] PORT,
   input wire logic MULTI,
   input wire logic [spdc_pkg::BYTE_BITS-1:0] DATA,
   input wire logic USE_HDR,
   input wire logic [spdc_pkg::CHAIN_W-1:0] CHAIN,
   output logic BUSY,
   output logic DONE,
   output logic [spdc_pkg::SEG_BITS-1:0] RX_STATUS,
   output logic [spdc_pkg::BYTE_BITS-1:0] RX_DATA
);
   localparam int FM = spdc_pkg::FRAME_MAX;

   spdc_pkg::spdc_cst_t st_q; // sequence state
   logic [spdc_pkg::CNT_W-1:0] ph_q; // half-period counter
   logic [spdc_pkg::BIT_CNT_W-1:0] bits_q; // bits left in frame
   logic [FM-1:0] tx_q; // outgoing frame, msb first
   logic [FM-1:0] rx_q; // incoming bits
   logic sdo_s1_q, sdo_s2_q; // sdo sampling
   logic hdr_q; // frame carries a header, latched with start
   logic ph_end; // half period elapsed

   assign ph_end = (ph_q == spdc_pkg::CNT_W'(HALF - 1));

   // two-flop sampling of sdo
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sdo_s1_q <= 1'b0;
         sdo_s2_q <= 1'b0;
      end else begin
         sdo_s1_q <= LINK.sdo;
         sdo_s2_q <= sdo_s1_q;
      end
   end

   // frame sequencer: select, clock low/high phases, release; clock idles low
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_q <= spdc_pkg::SPDC_C_IDLE;
         ph_q <= '0;
         bits_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         hdr_q <= 1'b0;
         DONE <= 1'b0;
      end else begin
         DONE <= 1'b0;
         ph_q <= ph_end ? '0 : ph_q + 1'b1;
         unique case (st_q)
            spdc_pkg::SPDC_C_IDLE: begin
               ph_q <= '0;
               if (START) begin // header optional, then address and byte
                  tx_q <= USE_HDR ? // one device: farthest and nearest alike
                     {spdc_pkg::HDR_ID, 1'b0, CHAIN, RNW, 2'h0, FEATURE,
                      1'b0, PORT, 3'h0, MULTI, DATA} :
                     {RNW, 2'h0, FEATURE, 1'b0, PORT, 3'h0, MULTI, DATA, 16'h0000};
                  bits_q <= USE_HDR ? spdc_pkg::BIT_CNT_W'(FM) :
                                      spdc_pkg::BIT_CNT_W'(spdc_pkg::WORD_BITS);
                  hdr_q <= USE_HDR; // status position fixed for the whole frame
                  st_q <= spdc_pkg::SPDC_C_LEAD;
               end
            end
            spdc_pkg::SPDC_C_LEAD: if (ph_end) st_q <= spdc_pkg::SPDC_C_LOW;
            spdc_pkg::SPDC_C_LOW: if (ph_end) st_q <= spdc_pkg::SPDC_C_HIGH;
            spdc_pkg::SPDC_C_HIGH: begin
               if (ph_end) begin // sample sdo, then falling edge and next bit
                  rx_q <= {rx_q[FM-2:0], sdo_s2_q};
                  tx_q <= {tx_q[FM-2:0], 1'b0};
                  bits_q <= bits_q - 1'b1;
                  st_q <= (bits_q == 1) ? spdc_pkg::SPDC_C_TAIL : spdc_pkg::SPDC_C_LOW;
               end
            end
            spdc_pkg::SPDC_C_TAIL: begin
               if (ph_end) begin
                  st_q <= spdc_pkg::SPDC_C_IDLE;
                  DONE <= 1'b1;
               end
            end
         endcase
      end
   end

   // results: status is first segment, data the last byte
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         RX_STATUS <= '0;
         RX_DATA <= '0;
      end else if (st_q == spdc_pkg::SPDC_C_TAIL && ph_end) begin
         RX_STATUS <= hdr_q ? rx_q[FM-1 -: 16] : rx_q[23:8];
         RX_DATA <= rx_q[7:0];
      end
   end

   // link pins
   assign LINK.cs_n = (st_q == spdc_pkg::SPDC_C_IDLE); // low through lead phase
   assign LINK.sclk = (st_q == spdc_pkg::SPDC_C_HIGH); // low after last bit
   assign LINK.sdi = tx_q[FM-1];
   assign BUSY = (st_q != spdc_pkg::SPDC_C_IDLE);

endmodule : spdc_ctrl

// file: test/spdc_assertions.sv
/*
 spdc_assertions: protocol checks on the link between controller and target.
 assumes: plain inputs tied to the shared link interface; controller divider at its default.
*/
`timescale 1ns/1ps
module spdc_assertions (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic sclk_q; // sclk one sample back
   logic [5:0] rise_cnt_q; // rising sclk seen in this frame
   logic [15:0] hist_q; // last sixteen sdi bits, oldest on top
   logic hdr_q; // frame opened with a header
   logic [3:0] hi_cnt_q; // cycles deselected, saturating
   logic rise; // rising sclk sample
   logic hdr_now; // header flag, valid from bit sixteen on
   assign rise = sclk & ~sclk_q;
   assign hdr_now = (rise_cnt_q == 6'h10) ? (hist_q[15:14] == 2'h1) : hdr_q;
   // edge finder
   always_ff @(posedge CLK_SYS) begin
      sclk_q <= RST ? 1'h0 : sclk;
   end
   // bit position inside the frame
   always_ff @(posedge CLK_SYS) begin
      if (RST || cs_n) begin
         rise_cnt_q <= 6'h00;
      end else if (rise && rise_cnt_q != 6'h3f) begin
         rise_cnt_q <= rise_cnt_q + 6'h01;
      end
   end
   // input history for the pass-through check
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         hist_q <= 16'h0000;
      end else if (rise && !cs_n) begin
         hist_q <= {hist_q[14:0], sdi};
      end
   end
   // header marker seen at the sixteenth bit
   always_ff @(posedge CLK_SYS) begin
      if (RST || cs_n) begin
         hdr_q <= 1'h0;
      end else if (rise && rise_cnt_q == 6'h10) begin
         hdr_q <= hdr_now;
      end
   end
   // idle time between frames
   always_ff @(posedge CLK_SYS) begin
      if (RST || !cs_n) begin
         hi_cnt_q <= 4'h0;
      end else if (hi_cnt_q != 4'hf) begin
         hi_cnt_q <= hi_cnt_q + 4'h1;
      end
   end
   property p_idle_low; cs_n |-> !sclk; endproperty
   a_idle_low: assert property (p_idle_low) else $error("sclk high while deselected");
   property p_cs_lead; $fell(cs_n) |-> !sclk [*3]; endproperty
   a_cs_lead: assert property (p_cs_lead) else $error("clock too soon after select");
   property p_high_phase; rise |-> sclk [*4] ##1 !sclk; endproperty
   a_high_phase: assert property (p_high_phase) else $error("sclk high phase length");
   property p_sdo_steady; sclk && sclk_q |-> $stable(sdo); endproperty
   a_sdo_steady: assert property (p_sdo_steady) else $error("sdo moved while sclk high");
   property p_sdo_quiet; hi_cnt_q >= 4'h4 |-> $stable(sdo); endproperty
   a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo moved while deselected");
   property p_stat_id; rise && !cs_n && rise_cnt_q < 6'h02 |-> sdo; endproperty
   a_stat_id: assert property (p_stat_id) else $error("status marker bit low");
   property p_stat_low;
      rise && !cs_n && rise_cnt_q >= 6'h08 && rise_cnt_q <= 6'h0f |-> !sdo;
   endproperty
   a_stat_low: assert property (p_stat_low) else $error("status low byte not zero");
   property p_pass;
      rise && !cs_n && hdr_now && rise_cnt_q >= 6'h10 && rise_cnt_q < 6'h20 |-> sdo == hist_q[15];
   endproperty
   a_pass: assert property (p_pass) else $error("header not passed through");
   property p_frame_len; $rose(cs_n) |-> rise_cnt_q == 6'h18 || rise_cnt_q == 6'h28; endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length");
   // main scenarios
   c_plain: cover property ($rose(cs_n) && rise_cnt_q == 6'h18);
   c_header: cover property ($rose(cs_n) && rise_cnt_q == 6'h28);
   c_pass: cover property (rise && hdr_now && rise_cnt_q == 6'h1f);
endmodule : spdc_assertions

// file: test/spdc_target_daisy_chain_frontend_tb_top.sv
/*
 bench top: controller and target joined by one link, a second target driven raw.
 assumes: default divider; register file modelled as {feature, port} on read data.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module spdc_target_daisy_chain_frontend_tb_top;
   logic clk_sys, rst, start, rnw, multi, use_hdr, busy, done;
   logic [4:0] feature, rd_feature_a, rd_feature_b, wr_feature_a, wr_feature_b;
   logic [2:0] port, rd_port_a, rd_port_b, wr_mask_a, wr_mask_b;
   logic [7:0] data, rx_data;
   logic [12:0] chain, chain_len_a;
   logic [5:0] fault;
   logic [15:0] rx_status;
   logic [23:0] wr_value_a, wr_value_b;
   logic rd_stb_a, wr_stb_a, wr_stb_b, hdr_seen_a, s0;
   int n_fail = 0, total_checks = 0, wr_cnt_a = 0, wr_cnt_b = 0, rd_cnt_a = 0, i, n0, r0;
   logic [4:0] fe;
   logic [2:0] pe, me;
   logic [7:0] de;
   spdc_if link_a();
   spdc_if link_b();
   // system clock, 20 ns
   initial begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end
   // strobe counters
   always @(negedge clk_sys) begin
      if (wr_stb_a === 1'h1) wr_cnt_a++;
      if (wr_stb_b === 1'h1) wr_cnt_b++;
      if (rd_stb_a === 1'h1) rd_cnt_a++;
   end
   spdc_ctrl spdc_ctrl_inst (.CLK_SYS(clk_sys), .RST(rst), .LINK(link_a.ctrl), .START(start),
      .RNW(rnw), .FEATURE(feature), .PORT(port), .MULTI(multi), .DATA(data), .USE_HDR(use_hdr),
      .CHAIN(chain), .BUSY(busy), .DONE(done), .RX_STATUS(rx_status), .RX_DATA(rx_data));
   spdc_target spdc_target_inst (.CLK_SYS(clk_sys), .RST(rst), .LINK(link_a.target),
      .FAULT(fault), .RD_DATA({rd_feature_a, rd_port_a}), .RD_FEATURE(rd_feature_a),
      .RD_PORT(rd_port_a), .RD_STB(rd_stb_a), .WR_STB(wr_stb_a), .WR_FEATURE(wr_feature_a),
      .WR_MASK(wr_mask_a), .WR_VALUE(wr_value_a), .CHAIN_LEN(chain_len_a),
      .HDR_SEEN(hdr_seen_a));
   // second target, fed by a raw driver that breaks the framing on purpose
   spdc_target spdc_target_inst_b (.CLK_SYS(clk_sys), .RST(rst), .LINK(link_b.target),
      .FAULT(fault), .RD_DATA({rd_feature_b, rd_port_b}), .RD_FEATURE(rd_feature_b),
      .RD_PORT(rd_port_b), .RD_STB(), .WR_STB(wr_stb_b), .WR_FEATURE(wr_feature_b),
      .WR_MASK(wr_mask_b), .WR_VALUE(wr_value_b), .CHAIN_LEN(), .HDR_SEEN());
   spdc_assertions spdc_assertions_inst (.CLK_SYS(clk_sys), .RST(rst), .sclk(link_a.sclk),
      .cs_n(link_a.cs_n), .sdi(link_a.sdi), .sdo(link_a.sdo));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   // one controller frame; returns twelve cycles after done, leaving idle time after
   task automatic xfer(input logic r, input logic [4:0] f, input logic [2:0] p, input logic m,
                       input logic [7:0] d, input logic h, input logic [12:0] c);
      int k;
      @(posedge clk_sys);
      start <= 1'h1; rnw <= r; feature <= f; port <= p; multi <= m;
      data <= d; use_hdr <= h; chain <= c; fault <= fault + 6'h0b;
      @(posedge clk_sys);
      start <= 1'h0;
      @(negedge clk_sys);
      `CHK({busy, link_a.cs_n, link_a.sclk}, 3'h4)
      for (k = 0; k < 3000 && done !== 1'h1; k++) @(negedge clk_sys);
      if (k == 3000) begin
         n_fail++;
         $display("[ERR] t=%0t no done", $time);
         tally_and_finish();
      end
      repeat (12) @(negedge clk_sys);
   endtask : xfer
   // raw mode-0 frame on the second link; sel low keeps it deselected
   task automatic shove(input logic [31:0] w, input int n, input logic sel);
      int j;
      @(posedge clk_sys);
      link_b.cs_n <= ~sel;
      repeat (4) @(posedge clk_sys);
      for (j = n - 1; j >= 0; j--) begin
         link_b.sdi <= w[j];
         repeat (4) @(posedge clk_sys);
         link_b.sclk <= 1'h1;
         repeat (4) @(posedge clk_sys);
         link_b.sclk <= 1'h0;
      end
      repeat (4) @(posedge clk_sys);
      link_b.cs_n <= 1'h1;
      link_b.sdi <= ~link_b.sdi; // released line shows no stale level
      repeat (12) @(negedge clk_sys);
   endtask : shove
   // main sequence
   initial begin
      rst = 1'h1; start = 1'h0; rnw = 1'h0; multi = 1'h0; use_hdr = 1'h0; feature = 5'h00;
      port = 3'h0; data = 8'h00; chain = 13'h0000; fault = 6'h2d;
      link_b.cs_n = 1'h1; link_b.sclk = 1'h0; link_b.sdi = 1'h0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'h0;
      repeat (4) @(negedge clk_sys);
      `CHK(wr_stb_a, 1'h0)
      `CHK(chain_len_a, 13'h0000)
      `CHK(hdr_seen_a, 1'h0)
      `CHK(link_a.cs_n, 1'h1)
      $display("test reset done");
      for (i = 0; i < 4; i++) begin // port codes 0 to 3, back to back
         fe = 5'h03 + i[4:0];
         pe = i[2:0];
         de = 8'h5a ^ i[7:0];
         me = (i < 3) ? (3'h1 << i) : 3'h0;
         n0 = wr_cnt_a;
         xfer(1'h0, fe, pe, 1'h0, de, 1'h0, 13'h0000);
         `CHK(rx_status, {2'h3, fault, 8'h00})
         `CHK(rx_data, {fe, pe})
         `CHK(wr_cnt_a, n0 + 1)
         `CHK(wr_feature_a, fe)
         `CHK(wr_mask_a, me)
         if (i < 3) `CHK(wr_value_a[i*8 +: 8], de)
      end
      $display("test single port writes done");
      for (i = 0; i < 2; i++) begin
         de = i ? 8'h02 : 8'h05;
         xfer(1'h0, 5'h04, 3'h0, 1'h1, de, 1'h0, 13'h0000);
         `CHK(wr_mask_a, 3'h7)
         `CHK(wr_value_a, {{8{de[2]}}, {8{de[1]}}, {8{de[0]}}})
      end
      $display("test multi port done");
      n0 = wr_cnt_a;
      r0 = rd_cnt_a;
      xfer(1'h1, 5'h1f, 3'h2, 1'h0, 8'h00, 1'h0, 13'h0000);
      `CHK(wr_cnt_a, n0)
      `CHK(rd_cnt_a, r0 + 1)
      `CHK(rx_data, {5'h1f, 3'h2})
      `CHK(rx_status, {2'h3, fault, 8'h00})
      $display("test read done");
      n0 = wr_cnt_a;
      xfer(1'h0, 5'h0c, 3'h1, 1'h0, 8'hc3, 1'h1, 13'h1abc);
      `CHK(rx_data, {5'h0c, 3'h1})
      `CHK(chain_len_a, 13'h1abc)
      `CHK(hdr_seen_a, 1'h1)
      `CHK(rx_status, {2'h3, fault, 8'h00})
      `CHK(wr_cnt_a, n0 + 1)
      `CHK(wr_value_a[15:8], 8'hc3)
      xfer(1'h0, 5'h05, 3'h0, 1'h0, 8'h11, 1'h0, 13'h0000);
      `CHK(chain_len_a, 13'h1abc)
      `CHK(hdr_seen_a, 1'h0)
      $display("test header done");
      @(posedge clk_sys);
      rst <= 1'h1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'h0;
      repeat (4) @(negedge clk_sys);
      `CHK(chain_len_a, 13'h0000)
      `CHK(hdr_seen_a, 1'h0)
      `CHK(link_a.sdo, 1'h0)
      $display("test mid-run reset done");
      s0 = link_b.sdo;
      n0 = wr_cnt_b;
      shove(32'h0310a5, 24, 1'h0); // clocks and data while deselected
      `CHK(wr_cnt_b, n0)
      `CHK(link_b.sdo, s0)
      shove(32'h00310a, 20, 1'h1); // short frame, half a byte
      `CHK(wr_cnt_b, n0)
      shove(32'h0310a53, 28, 1'h1); // one byte and four loose bits
      `CHK(wr_cnt_b, n0)
      shove(32'h0310a5, 24, 1'h1);
      `CHK(wr_cnt_b, n0 + 1)
      `CHK(wr_feature_b, 5'h03)
      `CHK(wr_mask_b, 3'h2)
      `CHK(wr_value_b[15:8], 8'ha5)
      $display("test raw link done");
      tally_and_finish();
   end
endmodule : spdc_target_daisy_chain_frontend_tb_top
